// ### hdl/parallel_slave_host_port.sv
// The implementer's own choice: the AHB-Lite interface to the registers.
`include "host_port_params.svh"
`default_nettype none

module parallel_slave_host_port
  import host_port_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Parallel data pins
  input  wire logic [7:0]  data_pin_i,
  output logic      [7:0]  data_pin_o,
  output logic      [7:0]  data_pin_oe_o,
  // Strobe pins
  input  wire logic        read_strobe_pin_n_i,
  input  wire logic        write_strobe_pin_n_i,
  input  wire logic        chip_select_pin_n_i,
  // Interrupt request
  output logic             host_port_irq_o
);
  import host_port_pkg::*;

  state_t s_q;
  state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Register index map; the byte address is four times the index
  //
  //   0x08  data latch: write output latch, read input latch (pins outside host mode)
  //   0x09  strobe pin data, bits 2:0, zero while analog
  //   0x0c  irq flags, bit 7 host port
  //   0x88  data direction, used only outside host mode
  //   0x89  control/status: 7 input full, 6 output full,
  //         5 overflow, 4 host select, 2:0 strobe directions
  //   0x8c  irq enables, bit 7 host port
  //   0x9f  analog config: 7 result format, 3:0 select field
  //
  // Unmapped or misaligned accesses read zero and write nothing.
  //

  ////////////////////////////////////////////////////////////////////////////

  logic        sel;
  logic        wr_now;
  logic        rd_now;
  logic [7:0]  din;
  logic [2:0]  re_pins;
  logic        re_digital;
  logic        take;
  logic        hit;
  logic [7:0]  idx;
  logic [7:0]  rd_val;
  logic [7:0]  wd;

  // Decode of the register bus and the host strobes
  logic        fw_rd;
  logic        fw_rd_data;
  logic        fw_wr;
  logic        wr_data;
  logic        wr_flags;
  logic        wr_ddir;
  logic        wr_ctrl;
  logic        wr_irq_en;
  logic        wr_acfg;
  logic        wr_end;
  logic        rd_start;
  logic        rd_end;
  logic        at_phase_two;
  logic        at_phase_four;
  logic [7:0]  ctrl_val;

  ////////////////////////////////////////////////////////////////////////////
  // Host access timing, in enabled clock cycles
  //
  //   pins low    -> seen two edges later through the synchroniser
  //   seen low    -> read drive starts on the next edge
  //   seen high   -> completion pending on the next edge
  //   pending     -> flags set at phase four after the next phase two,
  //                  three to six cycles later
  //
  // Limitation: strobes held for less than one cycle may be missed,
  // and a second access that ends while one is pending shares its flag
  // update. The trade keeps the block free of long counters.
  //
  // While ce_i is low nothing advances, so a host access that starts and
  // ends in a frozen stretch is lost; the register bus stalls instead.
  //

  always_comb begin
    s_d        = s_q;

    // Host strobes after the synchroniser; select gates both
    sel        = ~s_q.sync2[10];
    din        = s_q.sync2[7:0];
    wr_now     = s_q.mode & sel & ~s_q.sync2[9];
    rd_now     = s_q.mode & sel & ~s_q.sync2[8];

    // Strobe pins read back only while configured digital
    re_digital = (s_q.pcfg[2:1] == `STROBE_DIGITAL_SEL);
    re_pins    = re_digital ? s_q.sync2[10:8] : 3'h0;

    // Bus address phase
    take       = hsel_i & htrans_i[1] & hready_i & ce_i;
    hit        = (haddr_i[31:10] == 22'h0) & (haddr_i[1:0] == 2'h0);
    idx        = haddr_i[9:2];
    wd         = hwdata_i[7:0];

    // Pins pass two flops before anything looks at them
    s_d.sync1 = {chip_select_pin_n_i, write_strobe_pin_n_i,
                 read_strobe_pin_n_i, data_pin_i};
    s_d.sync2 = s_q.sync1;

    //////////////////////////////////////////////////////////////////////////
    // Strobe edges, seen only after synchronisation

    wr_end   = s_q.wr_act & ~wr_now;
    rd_start = rd_now & ~s_q.rd_act;
    rd_end   = s_q.rd_act & ~rd_now;

    // Phase counter decode
    at_phase_two  = (s_q.phase == `PHASE_TWO);
    at_phase_four = (s_q.phase == `PHASE_FOUR);

    //////////////////////////////////////////////////////////////////////////
    // Register bus decode

    fw_rd      = take & ~hwrite_i;
    // Only a host-mode read of the data latch has a side effect
    fw_rd_data = fw_rd & hit & (idx == `IDX_DATA_LATCH) & s_q.mode;

    // Data phase strobes, one per writable register
    fw_wr      = s_q.dph_wr & ce_i;
    wr_data    = fw_wr & (s_q.dph_idx == `IDX_DATA_LATCH);
    wr_flags   = fw_wr & (s_q.dph_idx == `IDX_IRQ_FLAGS);
    wr_ddir    = fw_wr & (s_q.dph_idx == `IDX_DATA_DIR);
    wr_ctrl    = fw_wr & (s_q.dph_idx == `IDX_CTRL_STATUS);
    wr_irq_en  = fw_wr & (s_q.dph_idx == `IDX_IRQ_ENABLES);
    wr_acfg    = fw_wr & (s_q.dph_idx == `IDX_ANALOG_CFG);

    // Unused bit three of the status byte reads zero
    ctrl_val   = {s_q.in_full, s_q.out_full, s_q.in_ovf, s_q.mode,
                  1'b0, s_q.re_dir};

    //////////////////////////////////////////////////////////////////////////
    // Read value, captured in the address phase

    rd_val = 8'h00;
    if (hit) begin
      case (idx)
        `IDX_DATA_LATCH: begin
          // Outside host mode the pins themselves are read back
          rd_val = s_q.mode ? s_q.in_latch : din;
        end
        `IDX_STROBE_DATA: begin
          rd_val = {5'h00, re_pins};
        end
        `IDX_IRQ_FLAGS: begin
          rd_val = {s_q.irq_flag, s_q.flags_other};
        end
        `IDX_DATA_DIR: begin
          rd_val = s_q.data_dir;
        end
        `IDX_CTRL_STATUS: begin
          rd_val = ctrl_val;
        end
        `IDX_IRQ_ENABLES: begin
          rd_val = {s_q.irq_en, s_q.enables_other};
        end
        `IDX_ANALOG_CFG: begin
          rd_val = {s_q.adfm, 3'h0, s_q.pcfg};
        end
        default: begin
          rd_val = 8'h00;
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Address phase

    s_d.dph_wr  = take & hwrite_i & hit;
    s_d.dph_idx = idx;
    if (fw_rd) begin
      s_d.hrdata = {24'h000000, rd_val};
    end
    // Reading the data latch frees it for the next host write
    if (fw_rd_data) begin
      s_d.in_full = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // Data phase writes; hardware sets further down win over these

    if (wr_data) begin
      s_d.out_latch = wd;
      if (s_q.mode) begin
        s_d.out_full = 1'b1;
      end
    end

    if (wr_flags) begin
      s_d.irq_flag    = wd[`BIT_HOST_IRQ];
      s_d.flags_other = wd[6:0];
    end

    if (wr_ddir) begin
      s_d.data_dir = wd;
    end

    if (wr_ctrl) begin
      // Full flags are status only; writes to them are dropped
      s_d.in_ovf = wd[`BIT_IN_OVF];
      s_d.mode   = wd[`BIT_MODE];
      s_d.re_dir = wd[2:0];
    end

    if (wr_irq_en) begin
      s_d.irq_en        = wd[7];
      s_d.enables_other = wd[6:0];
    end

    if (wr_acfg) begin
      s_d.adfm = wd[`BIT_ADFM];
      s_d.pcfg = wd[3:0];
    end

    //////////////////////////////////////////////////////////////////////////
    // Host side tracking

    s_d.phase  = s_q.phase + 2'h1;
    s_d.wr_act = wr_now;
    s_d.rd_act = rd_now;
    // Latch follows the bus while the write lasts; the last byte wins
    if (wr_now) begin
      s_d.in_latch = din;
    end
    // A read start beats a firmware reload in the same cycle
    if (rd_start) begin
      s_d.out_full = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // Completion lands on phase four after the next phase two

    if (s_q.pend) begin
      if (at_phase_two) begin
        s_d.seen_two = 1'b1;
      end
      if (s_q.seen_two & at_phase_four) begin
        s_d.irq_flag = 1'b1;
        if (s_q.pend_wr) begin
          s_d.in_full = 1'b1;
          if (s_q.in_full) begin
            s_d.in_ovf = 1'b1;
          end
        end
        s_d.pend     = 1'b0;
        s_d.pend_wr  = 1'b0;
        s_d.seen_two = 1'b0;
      end
    end
    // A new end while one is pending merges into the same flag update
    if (wr_end) begin
      s_d.pend    = 1'b1;
      s_d.pend_wr = 1'b1;
    end
    if (rd_end) begin
      s_d.pend = 1'b1;
    end

    // Leaving host mode drops both full flags, never the overflow
    if (~s_q.mode) begin
      s_d.in_full  = 1'b0;
      s_d.out_full = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Strobes and data idle high so no false edge follows reset
      s_q.sync1         <= 11'h7ff;
      s_q.sync2         <= 11'h7ff;
      s_q.out_latch     <= `RST_LATCH;
      s_q.in_latch      <= `RST_LATCH;
      s_q.in_full       <= 1'b0;
      s_q.out_full      <= 1'b0;
      s_q.in_ovf        <= 1'b0;
      s_q.mode          <= 1'b0;
      s_q.re_dir        <= `RST_CTRL_DIR;
      s_q.data_dir      <= `RST_DATA_DIR;
      s_q.irq_flag      <= 1'b0;
      s_q.flags_other   <= 7'h00;
      s_q.irq_en        <= 1'b0;
      s_q.enables_other <= 7'h00;
      s_q.adfm          <= 1'b0;
      s_q.pcfg          <= 4'h0;
      s_q.wr_act        <= 1'b0;
      s_q.rd_act        <= 1'b0;
      s_q.pend          <= 1'b0;
      s_q.pend_wr       <= 1'b0;
      s_q.seen_two      <= 1'b0;
      s_q.phase         <= 2'h0;
      s_q.dph_wr        <= 1'b0;
      s_q.dph_idx       <= 8'h00;
      s_q.hrdata        <= 32'h00000000;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Frozen clock stalls the bus rather than dropping a transfer
  assign hreadyout_o = ce_i;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = s_q.hrdata;

  // Strobes alone steer the pins in host mode
  assign data_pin_o    = s_q.out_latch;
  assign data_pin_oe_o = s_q.mode ? {8{s_q.rd_act}}
                                  : ~s_q.data_dir;
  assign host_port_irq_o = s_q.irq_flag & s_q.irq_en;

endmodule
`default_nettype wire

// ### hdl/host_port_params.svh
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_DATA_LATCH     8'h08
`define IDX_STROBE_DATA    8'h09
`define IDX_IRQ_FLAGS      8'h0c
`define IDX_DATA_DIR       8'h88
`define IDX_CTRL_STATUS    8'h89
`define IDX_IRQ_ENABLES    8'h8c
`define IDX_ANALOG_CFG     8'h9f

// Control/status, irq flag and analog config field positions
`define BIT_IN_FULL        7
`define BIT_OUT_FULL       6
`define BIT_IN_OVF         5
`define BIT_MODE           4
`define BIT_HOST_IRQ       7
`define BIT_ADFM           7

// Reset values
`define RST_CTRL_DIR       3'h7
`define RST_DATA_DIR       8'hff
`define RST_LATCH          8'h00

// Phases of the four-phase cycle, counted 0..3 from reset
`define PHASE_TWO          2'h1
`define PHASE_FOUR         2'h3

// Analog select pattern on bits 2:1 that leaves the strobe pins digital
`define STROBE_DIGITAL_SEL 2'h3

`endif

// ### hdl/host_port_pkg.sv
`default_nettype none
package host_port_pkg;

  typedef struct packed {
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [7:0]  out_latch;
    logic [7:0]  in_latch;
    logic        in_full;
    logic        out_full;
    logic        in_ovf;
    logic        mode;
    logic [2:0]  re_dir;
    logic [7:0]  data_dir;
    logic        irq_flag;
    logic [6:0]  flags_other;
    logic        irq_en;
    logic [6:0]  enables_other;
    logic        adfm;
    logic [3:0]  pcfg;
    logic        wr_act;
    logic        rd_act;
    logic        pend;
    logic        pend_wr;
    logic        seen_two;
    logic [1:0]  phase;
    logic        dph_wr;
    logic [7:0]  dph_idx;
    logic [31:0] hrdata;
  } state_t;

endpackage
`default_nettype wire

// ### dv/host_port_sva.sv
`default_nettype none
module host_port_sva (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic [7:0]  data_pin_oe_o,
  input wire logic        read_strobe_pin_n_i,
  input wire logic        write_strobe_pin_n_i,
  input wire logic        chip_select_pin_n_i,
  input wire logic        host_port_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sel_rd, acc, oe_on, wr_dph_q;
  logic [4:0] quiet_q;
  assign sel_rd = !chip_select_pin_n_i && !read_strobe_pin_n_i;
  assign acc = sel_rd || (!chip_select_pin_n_i && !write_strobe_pin_n_i);
  assign oe_on = data_pin_oe_o != 8'h00;
  // Saturating count of cycles with no selected strobe
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      quiet_q <= 5'h1f;
      wr_dph_q <= 1'b0;
    end else begin
      quiet_q <= acc ? 5'h0 : quiet_q + {4'h0, quiet_q != 5'h1f};
      wr_dph_q <= hsel_i && htrans_i[1] && hready_i && hwrite_i && ce_i;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_okay; hresp_o == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("resp not okay");
  property p_ready; hreadyout_o == ce_i; endproperty
  a_ready: assert property (p_ready) else $error("ready wrong");
  property p_upper; hrdata_o[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper data");
  property p_oe_all; oe_on |-> data_pin_oe_o == 8'hff; endproperty
  a_oe_all: assert property (p_oe_all) else $error("part drive");
  property p_oe_cause; $rose(oe_on) |-> $past(sel_rd, 3); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive cause");
  property p_oe_drop; (!sel_rd) [*4] |=> !oe_on; endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("drive stuck");
  property p_irq_cause;
    $rose(host_port_irq_o) |-> $past(wr_dph_q) || quiet_q < 5'd20;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq cause");
  property p_freeze;
    !ce_i |=> $stable(data_pin_oe_o) && $stable(host_port_irq_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("not frozen");
  c_read: cover property ($rose(oe_on));
  c_irq: cover property ($rose(host_port_irq_o));
  c_hold: cover property (!ce_i);
endmodule
`default_nettype wire

// ### dv/ext_cpu_model.sv
`default_nettype none
module ext_cpu_model (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] data_pin_o,
  input  wire logic [7:0] data_pin_oe_o,
  output wire logic [7:0] bus_o,
  output var  logic       rd_n_o,
  output var  logic       wr_n_o,
  output var  logic       cs_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drv_q = 8'h00;
  logic       on_q = 1'b0;
  initial {rd_n_o, wr_n_o, cs_n_o} = 3'h7;
  // A released bus shows the inverse of the last value, never a clean hold
  assign bus_o = (data_pin_oe_o != 8'h00) ? data_pin_o : on_q ? drv_q : ~drv_q;
  task automatic cycle(input logic wr, input logic sel,
                       input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk_i);
    drv_q <= d;
    on_q <= wr;
    cs_n_o <= !sel;
    rd_n_o <= wr;
    wr_n_o <= !wr;
    repeat (4) @(posedge ref_clk_i);
    q = bus_o;
    {rd_n_o, wr_n_o, cs_n_o} <= 3'h7;
    on_q <= 1'b0;
    // Long gap so two completions never merge
    repeat (14) @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// ### dv/parallel_slave_host_port_test.sv
`default_nettype none
module parallel_slave_host_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, hsel = 1'b0, hw = 1'b0;
  logic [1:0]  htr = 2'h0;
  logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, rv;
  logic [7:0]  bus, dpo, doe, b;
  logic        rdy, resp, rdn, wrn, csn, irq;
  int          n_mismatch = 0, comparisons = 0, cyc = 0;
  always #2.5 clk = ~clk;
  parallel_slave_host_port dut_u (.ref_clk_i(clk), .rst_i(rst), .ce_i(ce),
    .hsel_i(hsel), .haddr_i(ha), .htrans_i(htr), .hwrite_i(hw),
    .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(rdy), .hrdata_o(hrd),
    .hreadyout_o(rdy), .hresp_o(resp), .data_pin_i(bus), .data_pin_o(dpo),
    .data_pin_oe_o(doe), .read_strobe_pin_n_i(rdn),
    .write_strobe_pin_n_i(wrn), .chip_select_pin_n_i(csn),
    .host_port_irq_o(irq));
  ext_cpu_model cpu_u (.ref_clk_i(clk), .data_pin_o(dpo), .data_pin_oe_o(doe),
    .bus_o(bus), .rd_n_o(rdn), .wr_n_o(wrn), .cs_n_o(csn));
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    {hsel, htr, ha, hw} <= {1'b1, 2'h2, a, w};
    do @(posedge clk); while (rdy !== 1'b1);
    {hsel, htr, hwd} <= {1'b0, 2'h0, d};
    do @(posedge clk); while (rdy !== 1'b1);
    rv = hrd;
  endtask
  task automatic rd(input logic [31:0] a, e, input string nm);
    ahb(a, 1'b0, 32'h0);
    chk(nm, rv, e);
  endtask
  task automatic t_reset;
    rd(32'h224, 32'h07, "ctrl");
    rd(32'h30, 32'h0, "flags");
    rd(32'h27c, 32'h0, "analog");
    rd(32'h24, 32'h0, "pins");
    rd(32'h3fc, 32'h0, "unmapped");
    ahb(32'h27c, 1'b1, 32'h06);
    ahb(32'h224, 1'b1, 32'h17);
    ahb(32'h230, 1'b1, 32'h80);
    rd(32'h24, 32'h07, "pins");
  endtask
  task automatic t_write;
    cpu_u.cycle(1'b1, 1'b1, 8'h5a, b);
    rd(32'h224, 32'h97, "in_full");
    chk("irq", {31'h0, irq}, 32'h1);
    cpu_u.cycle(1'b1, 1'b1, 8'ha5, b);
    rd(32'h224, 32'hb7, "in_ovf");
    rd(32'h20, 32'ha5, "latch");
    ahb(32'h224, 1'b1, 32'hf7);
    rd(32'h224, 32'h37, "ro");
    cpu_u.cycle(1'b1, 1'b1, 8'hc3, b);
    ahb(32'h224, 1'b1, 32'h27);
    rd(32'h224, 32'h27, "off");
    ahb(32'h224, 1'b1, 32'h17);
    rd(32'h224, 32'h17, "clr");
  endtask
  task automatic t_read;
    ahb(32'h30, 1'b1, 32'h0);
    ahb(32'h20, 1'b1, 32'h3c);
    rd(32'h224, 32'h57, "out_full");
    cpu_u.cycle(1'b0, 1'b1, 8'h00, b);
    chk("cpu", {24'h0, b}, 32'h3c);
    rd(32'h224, 32'h17, "out_clr");
    rd(32'h30, 32'h80, "flag");
    ahb(32'h230, 1'b1, 32'h0);
    @(posedge clk);
    chk("mask", {31'h0, irq}, 32'h0);
    ahb(32'h30, 1'b1, 32'h0);
    cpu_u.cycle(1'b1, 1'b0, 8'h99, b);
    cpu_u.cycle(1'b0, 1'b0, 8'h00, b);
    rd(32'h224, 32'h17, "nocs");
    rd(32'h30, 32'h0, "nocs");
    ahb(32'h220, 1'b1, 32'h0);
    @(posedge clk);
    chk("ddir", {24'h0, doe}, 32'h0);
    ahb(32'h220, 1'b1, 32'hff);
  endtask
  task automatic t_hold;
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    chk("ready", {31'h0, rdy}, 32'h0);
    ce <= 1'b1;
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_write();
    t_read();
    t_hold();
    tally_and_finish();
  end
endmodule
bind parallel_slave_host_port host_port_sva chk_u (.*);
`default_nettype wire
